// ==== core/clock_divider.v ====
// Purpose: fractional rate generator producing a one-cycle tick on accumulator carry at a programmed rate
// Assumes: caller clamps the step below the accumulator range
// Notes:   phase accumulator, no division in hardware
`timescale 1ns/1ps
`default_nettype none
module clock_divider (
    input  wire        CLK,
    input  wire        RST,
    input  wire        run,
    input  wire [31:0] step,
    output reg         tick
);
    reg [31:0] acc_reg;
    wire [32:0] sum = {1'b0, acc_reg} + {1'b0, step};

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            acc_reg <= 32'h0000_0000;
            tick    <= 1'b0;
        end else if (run) begin
            acc_reg <= sum[31:0];
            tick    <= sum[32];
        end else begin
            tick    <= 1'b0;
        end
    end
endmodule // clock_divider
`default_nettype wire

// ==== core/clock_speed_defines.vh ====
// Purpose: constants for the clock speed control block
// Assumes: 40 MHz system clock, register port addressed by an 8-bit I/O address
// Notes:   register is write-only; state is visible only through the module outputs (clocks, oscillator enables, trim)
//
// Operation
// - reference is multiplied by four before the pll, base 131.07 kHz
// - cpu clock is the master clock divided by two
// - master clock drives peripherals, cpu clock drives the core
// - one 16-bit write-only control register at address 0x3D holds all controls
// - writing bit 8 selects and starts the resistor-trimmed oscillator
// - bit 9 with bit 8 clear selects crystal and pulses it to start
// - with bit 8 set, trim is bits 15..11 then bit 9
// - register resets to 0x0000, no reference running
// - without reference the pll runs at minimum, master clock below 100 kHz
// - bits 7..0 multiplier, master clock is (value+1) times base
// - bit 10 clear: sleep stops cpu clock, master clock keeps running
// - bit 10 set: sleep stops both cpu and master clock
// - after re-enable, full speed waits for oscillator restart; crystal longer
// - trim zero slowest, trim 0x3F fastest
`ifndef CLOCK_SPEED_DEFINES_VH
`define CLOCK_SPEED_DEFINES_VH

// ***********************
// register map
// ***********************
`define CSC_ADDR          8'h3D
`define CSC_RESET         16'h0000
`define CSC_MULT_MSB      7
`define CSC_MULT_LSB      0
`define CSC_RTO_BIT       8
`define CSC_CRO_BIT       9
`define CSC_IDLE_BIT      10
`define CSC_TRIM_MSB      15
`define CSC_TRIM_LSB      11

// ***********************
// timing
// ***********************
`define CLK_HZ            40000000
`define REF_HZ            32768
`define PRESCALE          4
`define RTO_START_NS      1000
`define CRO_START_NS      10000
`define RTO_START_CYC     ((`RTO_START_NS * 40 + 999) / 1000)
`define CRO_START_CYC     ((`CRO_START_NS * 40 + 999) / 1000)
`define MIN_PLL_HZ        65536
`define CRO_KICK_CYC      8

`endif

// ==== core/pll_clock_speed_control.v ====
// Purpose: clock speed control, reference select, pll model, cpu clock gating
// Assumes: single 40 MHz clock; generated clocks are enable-style square waves
// Notes:   the pll is modelled digitally by a phase accumulator
`timescale 1ns/1ps
`default_nettype none
`include "clock_speed_defines.vh"
module pll_clock_speed_control (
    input  wire        CLK,
    input  wire        RST,
    input  wire [7:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire        WR,
    input  wire        SLEEP,
    output reg         MASTER_CLOCK,
    output reg         CPU_CLOCK,
    output reg         RESISTOR_TRIMMED_OSCILLATOR_EN,
    output reg         CRYSTAL_OSCILLATOR_EN,
    output reg         CRYSTAL_KICK,
    output reg  [5:0]  RTO_TRIM,
    output reg         REFERENCE_STABLE,
    output reg         CPU_RUN
);
    // ***********************
    // control register
    // ***********************
    reg [15:0] csc_reg;
    wire       wr_hit = WR && (ADDR == `CSC_ADDR);

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            csc_reg <= `CSC_RESET;
        end else if (wr_hit) begin
            csc_reg <= WDATA;
        end
    end

    wire       rto_sel = csc_reg[`CSC_RTO_BIT];
    wire       cro_sel = csc_reg[`CSC_CRO_BIT] & ~rto_sel;
    wire       ref_on  = rto_sel | cro_sel;
    wire [7:0] mult    = csc_reg[`CSC_MULT_MSB:`CSC_MULT_LSB];
    wire       deep    = csc_reg[`CSC_IDLE_BIT];
    // trim 0 is slowest; larger codes speed the oscillator up
    wire [5:0] trim    = {csc_reg[`CSC_TRIM_MSB:`CSC_TRIM_LSB], csc_reg[`CSC_CRO_BIT]};

    // ***********************
    // constants
    // ***********************
    // counts kept at integer width, sliced on purpose
    localparam [31:0] RTO_START_FULL = `RTO_START_CYC;
    localparam [31:0] CRO_START_FULL = `CRO_START_CYC;
    localparam [31:0] KICK_FULL      = `CRO_KICK_CYC;
    localparam [9:0]  RTO_START      = RTO_START_FULL[9:0];
    localparam [9:0]  CRO_START      = CRO_START_FULL[9:0];
    localparam [3:0]  KICK_LEN       = KICK_FULL[3:0];
    // pll steps: toggle rate = 2 * f_mc / f_clk in 2^32 units
    localparam [63:0] BASE_FULL      = ((64'h2 * `REF_HZ * `PRESCALE) << 32) / `CLK_HZ;
    localparam [63:0] MIN_FULL       = ((64'h2 * `MIN_PLL_HZ) << 32) / `CLK_HZ;
    localparam [63:0] MAX_FULL       = 64'h0000_0000_FFFF_FFFF;
    localparam [31:0] MIN_STEP       = MIN_FULL[31:0];
    // start state machine
    localparam [1:0]  ST_OFF         = 2'h0;
    localparam [1:0]  ST_WAIT        = 2'h1;
    localparam [1:0]  ST_STABLE      = 2'h2;

    // ***********************
    // select edge detection
    // ***********************
    reg        rto_q_reg;
    reg        cro_q_reg;
    wire       rto_rise = rto_sel & ~rto_q_reg;
    wire       cro_rise = cro_sel & ~cro_q_reg;

    // both flops reset low like the idle select, so no false start after reset
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            rto_q_reg <= 1'b0;
            cro_q_reg <= 1'b0;
        end else begin
            rto_q_reg <= rto_sel;
            cro_q_reg <= cro_sel;
        end
    end

    // ***********************
    // oscillator pin controls
    // ***********************
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            RESISTOR_TRIMMED_OSCILLATOR_EN <= 1'b0;
            CRYSTAL_OSCILLATOR_EN          <= 1'b0;
            RTO_TRIM                       <= 6'h00;
        end else begin
            RESISTOR_TRIMMED_OSCILLATOR_EN <= rto_sel;
            CRYSTAL_OSCILLATOR_EN          <= cro_sel;
            // trim means nothing to the crystal, so it is held at zero
            RTO_TRIM                       <= rto_sel ? trim : 6'h00;
        end
    end

    // ***********************
    // crystal kick
    // ***********************
    reg [3:0] kick_cnt_reg;

    // crystal needs a short drive burst to begin oscillating
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            kick_cnt_reg <= 4'h0;
            CRYSTAL_KICK <= 1'b0;
        end else if (cro_rise) begin
            kick_cnt_reg <= KICK_LEN;
            CRYSTAL_KICK <= 1'b1;
        end else if (kick_cnt_reg > 4'h1) begin
            kick_cnt_reg <= kick_cnt_reg - 4'h1;
        end else begin
            kick_cnt_reg <= 4'h0;
            CRYSTAL_KICK <= 1'b0;
        end
    end

    // ***********************
    // start delay and stability
    // ***********************
    reg [1:0] start_state_reg;
    reg [1:0] start_state_next;
    reg [9:0] start_cnt_reg;
    reg [9:0] start_cnt_next;
    reg       stable_next;

    // a new select always restarts the count, even mid-count
    always @* begin
        start_state_next = start_state_reg;
        start_cnt_next   = start_cnt_reg;
        stable_next      = REFERENCE_STABLE;
        if (rto_rise) begin
            start_state_next = ST_WAIT;
            start_cnt_next   = RTO_START;
            stable_next      = 1'b0;
        end else if (cro_rise) begin
            start_state_next = ST_WAIT;
            start_cnt_next   = CRO_START;
            stable_next      = 1'b0;
        end else if (!ref_on) begin
            start_state_next = ST_OFF;
            start_cnt_next   = 10'h000;
            stable_next      = 1'b0;
        end else begin
            case (start_state_reg)
                ST_OFF: begin
                    start_state_next = ST_WAIT;
                end
                ST_WAIT: begin
                    if (start_cnt_reg != 10'h000) begin
                        start_cnt_next = start_cnt_reg - 10'h001;
                    end else begin
                        start_state_next = ST_STABLE;
                        stable_next      = 1'b1;
                    end
                end
                ST_STABLE: begin
                    stable_next = 1'b1;
                end
                default: begin
                    start_state_next = ST_OFF;
                    stable_next      = 1'b0;
                end
            endcase
        end
    end

    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            start_state_reg  <= ST_OFF;
            start_cnt_reg    <= 10'h000;
            REFERENCE_STABLE <= 1'b0;
        end else begin
            start_state_reg  <= start_state_next;
            start_cnt_reg    <= start_cnt_next;
            REFERENCE_STABLE <= stable_next;
        end
    end

    // ***********************
    // pll model
    // ***********************
    wire [63:0] mc_full;
    wire        mc_sat;
    wire [31:0] mc_step;
    wire [31:0] step;
    wire        mc_run;
    wire        mc_tick;

    // base = ref * 4, mc = (mult+1) * base; product kept wide so it cannot wrap
    assign mc_full = BASE_FULL * {56'h00_0000_0000_0000, mult} + BASE_FULL;
    // the 40 MHz grid cannot show more than about 20 MHz; clamp rather than wrap
    assign mc_sat  = (mc_full > MAX_FULL);
    assign mc_step = mc_sat ? 32'hFFFF_FFFF : mc_full[31:0];
    // not full speed until the reference has restarted
    assign step    = REFERENCE_STABLE ? mc_step : MIN_STEP;
    assign mc_run  = ~(SLEEP & deep);

    clock_divider u_pll (
        .CLK  (CLK),
        .RST  (RST),
        .run  (mc_run),
        .step (step),
        .tick (mc_tick)
    );

    // ***********************
    // master clock
    // ***********************
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            MASTER_CLOCK <= 1'b0;
        end else if (mc_tick) begin
            MASTER_CLOCK <= ~MASTER_CLOCK;
        end
    end

    // ***********************
    // cpu clock
    // ***********************
    // toggles on each master rising edge; core clock halts during any sleep
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            CPU_CLOCK <= 1'b0;
        end else if (mc_tick && !MASTER_CLOCK && !SLEEP) begin
            CPU_CLOCK <= ~CPU_CLOCK;
        end
    end

    // ***********************
    // core run flag
    // ***********************
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            CPU_RUN <= 1'b0;
        end else begin
            CPU_RUN <= ~SLEEP;
        end
    end
endmodule // pll_clock_speed_control
`default_nettype wire

// ==== sim/clock_speed_monitor.sv ====
// Purpose: port assertions for clock speed control
// Assumes: outputs follow a write two edges later
// Notes: idle bit shadowed here, register is write-only
`timescale 1ns/1ps
`default_nettype none
module clock_speed_monitor (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [7:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        SLEEP,
    input wire logic        MASTER_CLOCK,
    input wire logic        CPU_CLOCK,
    input wire logic        RESISTOR_TRIMMED_OSCILLATOR_EN,
    input wire logic        CRYSTAL_OSCILLATOR_EN,
    input wire logic        CRYSTAL_KICK,
    input wire logic [5:0]  RTO_TRIM,
    input wire logic        REFERENCE_STABLE,
    input wire logic        CPU_RUN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic idle_reg;
    always @(posedge CLK or posedge RST)
        if (RST) idle_reg <= 1'b0;
        else if (WR && ADDR == 8'h3D) idle_reg <= WDATA[10];
    sequence s_wr; WR && ADDR == 8'h3D; endsequence
    sequence s_deep; (idle_reg && SLEEP)[*3]; endsequence
    chk_rto_enable: assert property (s_wr |-> ##2 RESISTOR_TRIMMED_OSCILLATOR_EN == $past(WDATA[8], 2))
        else $error("rto enable wrong");
    chk_cro_enable: assert property (s_wr |-> ##2 CRYSTAL_OSCILLATOR_EN == ($past(WDATA[9], 2) && !$past(WDATA[8], 2)))
        else $error("crystal enable wrong");
    chk_trim_value: assert property (s_wr ##2 RESISTOR_TRIMMED_OSCILLATOR_EN |-> RTO_TRIM == $past({WDATA[15:11], WDATA[9]}, 2))
        else $error("trim wrong");
    chk_light_sleep: assert property (SLEEP[*2] |-> $stable(CPU_CLOCK) && !CPU_RUN)
        else $error("cpu clock ran in sleep");
    chk_deep_sleep: assert property (s_deep |-> $stable(MASTER_CLOCK))
        else $error("master clock ran in deep sleep");
    chk_kick_pulse: assert property ($rose(CRYSTAL_KICK) |-> CRYSTAL_KICK[*8] ##1 !CRYSTAL_KICK)
        else $error("kick length wrong");
    chk_rto_start: assert property ($rose(RESISTOR_TRIMMED_OSCILLATOR_EN) |-> ##[30:44] $rose(REFERENCE_STABLE))
        else $error("rto start delay wrong");
    chk_cro_start: assert property ($rose(CRYSTAL_OSCILLATOR_EN) |-> ##[380:410] $rose(REFERENCE_STABLE))
        else $error("crystal start delay wrong");
endmodule // clock_speed_monitor
bind pll_clock_speed_control clock_speed_monitor clock_speed_monitor_i (.*);
`default_nettype wire

// ==== sim/ref_osc_model.sv ====
// Purpose: external resistor or crystal across the oscillator pins
// Assumes: crystal needs the kick pulse while selected
// Notes: no frequency modelled, running flag only
`timescale 1ns/1ps
`default_nettype none
module ref_osc_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rto_en,
    input  wire logic cro_en,
    input  wire logic kick,
    output var logic  running
);
    logic kicked_reg;
    always @(posedge clk or posedge rst)
        if (rst) kicked_reg <= 1'b0;
        else kicked_reg <= cro_en && (kicked_reg || kick);
    always @* running = rto_en || kicked_reg;
endmodule // ref_osc_model
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: self-checking bench for clock speed control
// Assumes: inputs change at falling edge
// Notes: clock rates judged by edge counts
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, slp = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wd = 16'h0000;
    wire mc, cpu, ren, cen, kick, stb, run, osc;
    wire [5:0] trim;
    int bad_count = 0, n_tests = 0, cyc = 0;
    integer mc_n, cpu_n;
    always #12.5 clk = ~clk;
    pll_clock_speed_control pll_clock_speed_control_i (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wd), .WR(wr),
        .SLEEP(slp), .MASTER_CLOCK(mc), .CPU_CLOCK(cpu), .RESISTOR_TRIMMED_OSCILLATOR_EN(ren),
        .CRYSTAL_OSCILLATOR_EN(cen), .CRYSTAL_KICK(kick), .RTO_TRIM(trim), .REFERENCE_STABLE(stb), .CPU_RUN(run));
    ref_osc_model ref_osc_model_i (.clk(clk), .rst(rst), .rto_en(ren), .cro_en(cen), .kick(kick), .running(osc));
    task end_sim;
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task near(input integer got, input int exp, input int tol);
        n_tests++;
        if ($isunknown(got) || got > exp + tol || got < exp - tol) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // edge counts, limited to the 40 MHz sampling grid
    task measure(input int n);
        logic pm, pc;
        mc_n = 0;
        cpu_n = 0;
        pm = mc;
        pc = cpu;
        repeat (n) begin
            @(negedge clk);
            mc_n += (mc && !pm);
            cpu_n += (cpu && !pc);
            pm = mc;
            pc = cpu;
        end
    endtask
    task t_idle;
        repeat (2) @(negedge clk);
        chk({run, ren, cen, trim}, 32'h0000_0100);
        measure(10000);
        near(mc_n, 16, 1);
    endtask
    task t_rto;
        wreg(8'h3C, 16'h0100);
        chk(ren, 32'h0000_0000);
        wreg(8'h3D, 16'h1300);
        chk({ren, cen, trim}, 32'h0000_0085);
        repeat (45) @(negedge clk);
        chk(stb, 32'h0000_0001);
        for (int m = 0; m < 16; m += 5) begin
            wreg(8'h3D, 16'h1300 | 16'(m));
            measure(10000);
            near(mc_n, (m + 1) * 32768 / 1000, 1);
            near(cpu_n, (m + 1) * 16384 / 1000, 1);
        end
    endtask
    task t_sleep(input logic [15:0] d, input int exp_mc);
        wreg(8'h3D, d);
        slp = 1'b1;
        repeat (2) @(negedge clk);
        measure(2000);
        chk({cpu_n[7:0], run}, 32'h0000_0000);
        near(mc_n, exp_mc, 1);
        slp = 1'b0;
    endtask
    task t_cro;
        wreg(8'h3D, 16'h0000);
        wreg(8'h3D, 16'h0200);
        chk({ren, cen, trim}, 32'h0000_0040);
        repeat (300) @(negedge clk);
        chk(stb, 32'h0000_0000);
        repeat (120) @(negedge clk);
        chk({stb, osc}, 32'h0000_0003);
        wreg(8'h3D, 16'h0300);
        chk({ren, cen, trim, stb}, 32'h0000_0102);
        repeat (45) @(negedge clk);
        chk(stb, 32'h0000_0001);
        wreg(8'h3D, 16'hFB00);
        chk({ren, cen, trim}, 32'h0000_00BF);
        wreg(8'h3D, 16'h0100);
        chk({ren, cen, trim}, 32'h0000_0080);
    endtask
    task t_reset;
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk({mc, cpu, ren, cen, kick, trim, stb, run}, 32'h0000_0000);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk({ren, cen, stb, run}, 32'h0000_0001);
    endtask
    // hang guard, run needs about 55000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 70000) begin
            bad_count++;
            end_sim;
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_idle;
        t_rto;
        t_sleep(16'h1303, 26);
        t_sleep(16'h1703, 0);
        t_cro;
        t_reset;
        end_sim;
    end
endmodule // tb
`default_nettype wire
